// ---- src/lock_current_fault_response.v ----
// Current-limit motor lock detector with configurable fault response.
`timescale 1ns/1ps
`default_nettype none
`include "lock_fault_defines.vh"

module lock_current_fault_response #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] current_ma,
	output reg         power_stage_hiz,
	output reg  [2:0]  high_side_on,
	output reg  [2:0]  low_side_on,
	input  wire        fault_indicator_pin_n_in,
	output wire        fault_indicator_pin_n_out,
	output reg         fault_indicator_pin_n_oe
);

	// ======================================================================
	// States and drive actions
	localparam ST_RUN     = 2'b00;
	localparam ST_LATCHED = 2'b01;
	localparam ST_WAIT    = 2'b10;
	localparam ST_REPORT  = 2'b11;
	localparam ACT_NONE   = 2'b00;
	localparam ACT_HIZ    = 2'b01;
	localparam ACT_HIGH   = 2'b10;
	localparam ACT_LOW    = 2'b11;
	localparam RESP_OKAY  = 2'b00;
	localparam RESP_DEC   = 2'b11;
	// ======================================================================
	// Lookup functions
	function [17:0] deg_ticks;
		input [3:0] code;
		reg   [31:0] us;
		reg   [31:0] q;
		begin
			case (code)
				4'h3:    us = `DEG_3_US;
				4'h4:    us = `DEG_4_US;
				4'h5:    us = `DEG_5_US;
				4'h6:    us = `DEG_6_US;
				4'h7:    us = `DEG_7_US;
				4'h8:    us = `DEG_8_US;
				4'h9:    us = `DEG_9_US;
				4'ha:    us = `DEG_A_US;
				4'hb:    us = `DEG_B_US;
				4'hc:    us = `DEG_C_US;
				4'hd:    us = `DEG_D_US;
				4'he:    us = `DEG_E_US;
				4'hf:    us = `DEG_F_US;
				default: us = `DEG_2_US;
			endcase
			q = us / `TICK_US;
			deg_ticks = q[17:0];
		end
	endfunction
	function [17:0] wait_ticks;
		input [3:0] code;
		reg   [31:0] ms;
		reg   [31:0] q;
		begin
			case (code)
				4'h0:    ms = `WAIT_0_MS;
				4'h1:    ms = `WAIT_1_MS;
				4'h2:    ms = `WAIT_2_MS;
				default: ms = (code - 32'd1) * `WAIT_STEP_MS;
			endcase
			q = (ms * 32'd1000) / `TICK_US;
			wait_ticks = q[17:0];
		end
	endfunction
	function [15:0] thr_ma;
		input [3:0] code;
		reg   [31:0] ma;
		begin
			case (code)
				4'h0:    ma = `THR_0_MA;
				4'h1:    ma = `THR_1_MA;
				4'h2:    ma = `THR_2_MA;
				4'he:    ma = `THR_E_MA;
				4'hf:    ma = `THR_F_MA;
				default: ma = (code - 32'd1) * `THR_STEP_MA;
			endcase
			thr_ma = ma[15:0];
		end
	endfunction
	function [1:0] action_of;
		input [3:0] m;
		begin
			case (m)
				4'h2, 4'h6: action_of = ACT_HIGH;
				4'h3, 4'h7: action_of = ACT_LOW;
				default:    action_of = ACT_HIZ;
			endcase
		end
	endfunction
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction
	// ======================================================================
	// Registers and state
	reg  [31:0] cfg;
	reg  [3:0]  retry_limit;
	reg         sw_clear;
	reg  [1:0]  state;
	reg  [1:0]  action;
	reg  [3:0]  retry_cnt;
	reg  [17:0] timer;
	reg         over;
	reg  [2:0]  pin_sync;
	reg         pin_level;
	wire        tick;
	wire [3:0]  mode    = cfg[`MODE_MSB:`MODE_LSB];
	wire        enabled = (mode <= 4'h8);
	tick_divider #(.DIV(TICK_CYCLES)) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);
	// ======================================================================
	// AXI4-Lite write channel
	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			cfg          <= `CFG_RESET;
			retry_limit  <= `RETRY_LIMIT_RESET;
			sw_clear     <= 1'b0;
		end else begin
			sw_clear <= 1'b0;
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				case (aw_addr[7:2])
					`CFG_OFFSET >> 2:
						cfg <= merge(cfg, w_data, w_strb);
					`CONTROL_OFFSET >> 2: begin
						if (w_strb[0]) begin
							sw_clear    <= w_data[`CLEAR_BIT];
							retry_limit <= w_data[`LIMIT_MSB:`LIMIT_LSB];
						end
					end
					`STATUS_OFFSET >> 2:
						s_axi_bresp <= RESP_OKAY;
					default:
						s_axi_bresp <= RESP_DEC;
				endcase
			end
		end
	end
	// ======================================================================
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr[7:2])
				`CFG_OFFSET >> 2: s_axi_rdata <= cfg;
				`STATUS_OFFSET >> 2:
					s_axi_rdata <= {21'h00_0000, pin_level,
						state != ST_RUN, over, retry_cnt, action, state};
				`CONTROL_OFFSET >> 2:
					s_axi_rdata <= {24'h00_0000, retry_limit, 4'h0};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_DEC;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ======================================================================
	// Fault pin readback; the first stage feeds only the second.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync  <= 3'b111;
			pin_level <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[1:0], fault_indicator_pin_n_in};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
		end
	end
	// ======================================================================
	// Lock detection and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			over      <= 1'b0;
			state     <= ST_RUN;
			action    <= ACT_NONE;
			retry_cnt <= 4'h0;
			timer     <= 18'h0_0000;
		end else begin
			// Threshold compare is registered to keep the path short.
			over <= enabled && (current_ma > thr_ma(cfg[`THR_MSB:`THR_LSB]));
			case (state)
				ST_RUN: begin
					action <= ACT_NONE;
					if (!over)
						timer <= 18'h0_0000;
					else if (timer >= deg_ticks(cfg[`DEG_MSB:`DEG_LSB])) begin
						timer <= 18'h0_0000;
						if (mode <= 4'h3) begin
							state  <= ST_LATCHED;
							action <= action_of(mode);
						end else if (mode <= 4'h7) begin
							action <= action_of(mode);
							if (retry_cnt >= retry_limit) begin
								state <= ST_LATCHED;
							end else begin
								retry_cnt <= retry_cnt + 4'h1;
								state     <= ST_WAIT;
							end
						end else begin
							state <= ST_REPORT;
						end
					end else if (tick)
						timer <= timer + 18'h0_0001;
				end
				ST_WAIT: begin
					if (timer >= wait_ticks(cfg[`WAIT_MSB:`WAIT_LSB])) begin
						timer  <= 18'h0_0000;
						state  <= ST_RUN;
						action <= ACT_NONE;
					end else if (tick)
						timer <= timer + 18'h0_0001;
				end
				ST_REPORT: begin
					// Report mode never touches the stage, only the pin.
					action <= ACT_NONE;
					if (!over || mode != 4'h8)
						state <= ST_RUN;
				end
				ST_LATCHED: begin
					if (sw_clear) begin
						state     <= ST_RUN;
						action    <= ACT_NONE;
						retry_cnt <= 4'h0;
						timer     <= 18'h0_0000;
					end
				end
				default:
					state <= ST_RUN;
			endcase
		end
	end
	// ======================================================================
	// Power stage and fault pin drive
	assign fault_indicator_pin_n_out = 1'b0;
	always @(posedge aclk) begin
		if (!aresetn) begin
			power_stage_hiz          <= 1'b0;
			high_side_on             <= 3'b000;
			low_side_on              <= 3'b000;
			fault_indicator_pin_n_oe <= 1'b0;
		end else begin
			power_stage_hiz          <= (action == ACT_HIZ);
			high_side_on             <= {3{action == ACT_HIGH}};
			low_side_on              <= {3{action == ACT_LOW}};
			fault_indicator_pin_n_oe <= (state != ST_RUN);
		end
	end

endmodule // lock_current_fault_response

`default_nettype wire

// ---- src/lock_fault_defines.vh ----
// Register map, field positions and timing constants for the lock fault block.
`ifndef LOCK_FAULT_DEFINES_VH
`define LOCK_FAULT_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define CFG_OFFSET        8'h00
`define STATUS_OFFSET     8'h04
`define CONTROL_OFFSET    8'h08

// ==========================================================================
// Reset values
`define CFG_RESET         32'h0000_0000
`define RETRY_LIMIT_RESET 4'h3

// ==========================================================================
// Configuration field positions
`define MODE_MSB          18
`define MODE_LSB          15
`define DEG_MSB           14
`define DEG_LSB           11
`define WAIT_MSB          10
`define WAIT_LSB          7
`define THR_MSB           22
`define THR_LSB           19

// Control field positions
`define CLEAR_BIT         0
`define LIMIT_MSB         7
`define LIMIT_LSB         4

// ==========================================================================
// Timing: clock rate and the tick that all timers count
`define CLK_MHZ           10
`define TICK_US           100
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)

// Deglitch times in microseconds, codes 2 to F
`define DEG_2_US          200
`define DEG_3_US          500
`define DEG_4_US          1000
`define DEG_5_US          2500
`define DEG_6_US          5000
`define DEG_7_US          7500
`define DEG_8_US          10000
`define DEG_9_US          25000
`define DEG_A_US          50000
`define DEG_B_US          75000
`define DEG_C_US          100000
`define DEG_D_US          200000
`define DEG_E_US          500000
`define DEG_F_US          1000000

// Retry wait times in milliseconds
`define WAIT_0_MS         300
`define WAIT_1_MS         500
`define WAIT_2_MS         1000
`define WAIT_STEP_MS      1000

// Lock thresholds in milliamperes
`define THR_0_MA          125
`define THR_1_MA          250
`define THR_2_MA          500
`define THR_STEP_MA       500
`define THR_E_MA          7000
`define THR_F_MA          8000

`endif

// ---- src/tick_divider.v ----
// Divider that turns the system clock into a one-cycle timer tick enable.
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
	parameter DIV = 1000
) (
	input  wire        aclk,
	input  wire        aresetn,
	output reg         tick
);

	// ======================================================================
	// Divider
	reg  [15:0] count;

	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else if (count == DIV[15:0] - 16'h0001) begin
			count <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick  <= 1'b0;
		end
	end

endmodule // tick_divider

`default_nettype wire

// ---- test/lock_fault_asserts.sv ----
// Port checker for the lock fault response block.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module lock_fault_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        power_stage_hiz,
	input wire logic [2:0]  high_side_on,
	input wire logic [2:0]  low_side_on,
	input wire logic        fault_indicator_pin_n_out,
	input wire logic        fault_indicator_pin_n_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_one_action;
		$onehot0({power_stage_hiz, |high_side_on, |low_side_on});
	endproperty
	a_one_action: assert property (p_one_action)
		else $error("tristate and brake overlap");
	property p_hs_whole;
		high_side_on != 3'h0 |-> high_side_on == 3'h7;
	endproperty
	a_hs_whole: assert property (p_hs_whole)
		else $error("partial high side brake");
	property p_ls_whole;
		low_side_on != 3'h0 |-> low_side_on == 3'h7;
	endproperty
	a_ls_whole: assert property (p_ls_whole)
		else $error("partial low side brake");
	property p_pin_low;
		fault_indicator_pin_n_out == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low)
		else $error("fault pin would drive high");
	// The reset check must stay live while reset is low.
	property p_reset;
		disable iff (1'b0) !aresetn |=> !fault_indicator_pin_n_oe
			&& !power_stage_hiz && high_side_on == 3'h0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_r_answer;
		s_ar_take |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read answer late");
	property p_drive_flags;
		power_stage_hiz || high_side_on != 3'h0 || low_side_on != 3'h0
			|-> fault_indicator_pin_n_oe;
	endproperty
	a_drive_flags: assert property (p_drive_flags)
		else $error("stage action without fault indication");
endmodule // lock_fault_checker
bind lock_current_fault_response lock_fault_checker chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .power_stage_hiz(power_stage_hiz),
	.high_side_on(high_side_on), .low_side_on(low_side_on),
	.fault_indicator_pin_n_out(fault_indicator_pin_n_out),
	.fault_indicator_pin_n_oe(fault_indicator_pin_n_oe));
`default_nettype wire

// ---- test/motor_current_model.sv ----
// Model of the motor current sense and the pulled-up fault pin.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Model
module motor_current_model (
	input wire logic [15:0] load_ma,
	input wire logic        power_stage_hiz,
	input wire logic [2:0]  high_side_on,
	input wire logic [2:0]  low_side_on,
	input wire logic        pin_oe,
	output logic [15:0]     current_ma,
	output logic            pin_level
);
	// A tristated or braked stage gives no torque, so the current collapses.
	assign current_ma = (power_stage_hiz || |high_side_on || |low_side_on)
		? 16'h0000 : load_ma;
	// Open drain with a pull-up: released means high.
	assign pin_level = pin_oe ? 1'b0 : 1'b1;
endmodule // motor_current_model
`default_nettype wire

// ---- test/tb_lock_current_fault_response.sv ----
// Self-checking bench for the lock fault response block.
`timescale 1ns/1ps
`default_nettype none
module tb_lock_current_fault_response;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd_v;
	logic [1:0] bresp, rresp, act;
	logic [2:0] hs, ls;
	logic [15:0] load = 0, cur;
	logic hiz, oe, pin;
	int err_count = 0, checks = 0;
	initial forever #50 aclk = ~aclk;
	lock_current_fault_response #(.TICK_CYCLES(2)) dut (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .current_ma(cur), .power_stage_hiz(hiz),
		.high_side_on(hs), .low_side_on(ls), .fault_indicator_pin_n_in(pin),
		.fault_indicator_pin_n_out(), .fault_indicator_pin_n_oe(oe));
	motor_current_model far (.load_ma(load), .power_stage_hiz(hiz),
		.high_side_on(hs), .low_side_on(ls), .pin_oe(oe),
		.current_ma(cur), .pin_level(pin));
	// ==========
	// Tasks
	task tally_and_finish;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Waits as long as it takes; only the watchdog ends a hung write.
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk(bresp, e);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [1:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd_v = rdata;
		chk(rresp, e);
		rready <= 1'b0;
	endtask
	task outs(input logic [1:0] a, input logic p);
		chk(hiz, a == 1);
		chk(hs, a == 2 ? 7 : 0);
		chk(ls, a == 3 ? 7 : 0);
		chk(pin, p);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// ==========
	// Sequence
	initial begin
		wait_n(2);
		aresetn <= 1'b1;
		rd(8'h00, 0);
		chk(rd_v, 32'h0000_0000);
		rd(8'h08, 0);
		chk(rd_v, 32'h0000_0030);
		wr(8'h00, 32'h007F_FF80, 0);
		rd(8'h00, 0);
		chk(rd_v, 32'h007F_FF80);
		wr(8'h04, 32'hFFFF_FFFF, 0);
		wr(8'h0C, 32'h0000_0001, 3);
		rd(8'h0C, 3);
		chk(rd_v, 32'h0000_0000);
		wr(8'h08, 32'h0000_0011, 0);
		for (int m = 0; m < 16; m++) if (m < 4 || m > 7) begin
			act = m < 2 ? 1 : m == 2 ? 2 : m == 3 ? 3 : 0;
			wr(8'h00, m << 15, 0);
			load <= 16'h03E8;
			wait_n(30);
			outs(act, m > 8);
			load <= 16'h0000;
			wr(8'h08, 32'h0000_0011, 0);
			wait_n(5);
			outs(0, 1);
		end
		// One retry per mode keeps the run short; the wait itself is long.
		for (int m = 4; m < 8; m++) begin
			act = m < 6 ? 1 : m == 6 ? 2 : 3;
			wr(8'h00, m << 15, 0);
			load <= 16'h03E8;
			wait_n(30);
			rd(8'h04, 0);
			chk(rd_v[1:0], 2);
			wait_n(5800);
			rd(8'h04, 0);
			chk(rd_v[1:0], 2);
			wait_n(400);
			rd(8'h04, 0);
			chk(rd_v[7:0], {4'h1, act, 2'h1});
			outs(act, 0);
			load <= 16'h0000;
			wr(8'h08, 32'h0000_0011, 0);
		end
		wr(8'h00, 32'h0001_2000, 0);
		load <= 16'h007D;
		wait_n(60);
		chk(pin, 1);
		repeat (6) begin
			load <= 16'h007E;
			wait_n(12);
			load <= 16'h0000;
			wait_n(1);
		end
		chk(pin, 1);
		load <= 16'h007E;
		wait_n(40);
		outs(2, 0);
		rd(8'h04, 0);
		chk(rd_v[10:0], 11'h209);
		tally_and_finish;
	end
	initial begin
		wait_n(40000);
		err_count++;
		tally_and_finish;
	end
endmodule // tb_lock_current_fault_response
`default_nettype wire
